// [core/asc_snoop_config.sv]
// module: i2c register slave, sideband snoop monitor and lane power control
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - polarity bit 0x04[3]: 0 pins as named, 1 pins swapped for snooping
// - polarity bit resets to 0, monitor starts with named polarity
// - orientation held in 0x04[4]; polarity bit may follow it
// - share bit 0x05[1]=0 at reset: aux on aux pair, low-speed on own pins
// - share bit 1: aux and low-speed both snooped on aux pair
// - monitor reports level and edge of the aux and low-speed lines matching the enabled mode
// - passive aux monitor; wiring must match expected polarity
// - i2c address 0x30..0x33 chosen by four-level address strap
// - unused main lanes powered down in d3 or when fewer than four lanes
// - lane order 0 keeps lane numbering; board wires lanes one to one
module asc_snoop_config
(
    // clock, reset, enable
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // pins from outside (asynchronous)
    input  wire asc_pkg::asc_pins_s    pins,
    // i2c data drive, open drain, low enable drives low
    output logic                       sdaOut,
    output logic                       sdaOeN,
    // snoop monitor results
    output asc_pkg::asc_snoop_s        snoop,
    // lane power and configuration view
    output logic [asc_pkg::LANES-1:0]  lanePowerDown,
    output logic [6:0]                 slaveAddr,
    output logic [7:0]                 orientCtrl,
    output logic [7:0]                 shareCtrl
);

    // ---------------------------------------------------------------
    // synchroniser: stage one feeds stage two only
    // ---------------------------------------------------------------
    asc_pkg::asc_pins_s pinsMeta_reg;
    asc_pkg::asc_pins_s pinsSync_reg;
    logic               prevScl_reg;
    logic               prevSda_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pinsMeta_reg <= '0;
            pinsSync_reg <= '0;
            prevScl_reg  <= 1'b1;
            prevSda_reg  <= 1'b1;
        end
        else if (ce)
        begin
            pinsMeta_reg <= pins;
            pinsSync_reg <= pinsMeta_reg;
            prevScl_reg  <= pinsSync_reg.scl;
            prevSda_reg  <= pinsSync_reg.sda;
        end
    end

    // ---------------------------------------------------------------
    // address strap, caught once after reset release
    // ---------------------------------------------------------------
    logic [6:0] addr_reg;
    logic [6:0] addr_next;
    logic [1:0] strapWait_reg;
    logic [1:0] strapWait_next;

    always_comb
    begin
        addr_next      = addr_reg;
        strapWait_next = strapWait_reg;
        // wait until the strap has crossed both synchroniser stages
        if (strapWait_reg != 2'h3)
        begin
            strapWait_next = strapWait_reg + 2'h1;
        end
        if (strapWait_reg == 2'h2)
        begin
            // 11 tied high, 10 strong pull-up, 01 weak pull-up, 00 ground
            addr_next = asc_pkg::I2C_ADDR_BASE | {5'h00, pinsSync_reg.addrStrap};
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            addr_reg      <= asc_pkg::I2C_ADDR_BASE;
            strapWait_reg <= 2'h0;
        end
        else if (ce)
        begin
            addr_reg      <= addr_next;
            strapWait_reg <= strapWait_next;
        end
    end

    // ---------------------------------------------------------------
    // i2c slave and register file
    // ---------------------------------------------------------------
    asc_pkg::asc_i2c_state_e state_reg;
    asc_pkg::asc_i2c_state_e state_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic       rw_reg;
    logic       rw_next;
    logic       first_reg;
    logic       first_next;
    logic       nack_reg;
    logic       nack_next;
    logic       drive_reg;
    logic       drive_next;
    logic [7:0] orient_reg;
    logic [7:0] orient_next;
    logic [7:0] share_reg;
    logic [7:0] share_next;

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    assign sclRise   = pinsSync_reg.scl && !prevScl_reg;
    assign sclFall   = !pinsSync_reg.scl && prevScl_reg;
    assign startCond = pinsSync_reg.scl && prevScl_reg && prevSda_reg && !pinsSync_reg.sda;
    assign stopCond  = pinsSync_reg.scl && prevScl_reg && !prevSda_reg && pinsSync_reg.sda;

    // unmapped offsets read as zero
    function automatic logic [7:0] readReg(input logic [7:0] ofs,
                                           input logic [7:0] orientVal,
                                           input logic [7:0] shareVal);
        logic [7:0] val;
        val = 8'h00;
        if (ofs == asc_pkg::ORIENT_CTRL_OFS)
        begin
            val = orientVal;
        end
        else if (ofs == asc_pkg::SHARE_CTRL_OFS)
        begin
            val = shareVal;
        end
        return val;
    endfunction

    always_comb
    begin
        state_next  = state_reg;
        shift_next  = shift_reg;
        tx_next     = tx_reg;
        cnt_next    = cnt_reg;
        ptr_next    = ptr_reg;
        rw_next     = rw_reg;
        first_next  = first_reg;
        nack_next   = nack_reg;
        drive_next  = drive_reg;
        orient_next = orient_reg;
        share_next  = share_reg;
        if (stopCond)
        begin
            state_next = asc_pkg::I2C_IDLE;
            drive_next = 1'b0;
        end
        else if (startCond)
        begin
            state_next = asc_pkg::I2C_ADDR;
            cnt_next   = 4'h0;
            drive_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                asc_pkg::I2C_ADDR, asc_pkg::I2C_WBYTE:
                begin
                    if (sclRise)
                    begin
                        shift_next = {shift_reg[6:0], pinsSync_reg.sda};
                        cnt_next   = cnt_reg + 4'h1;
                    end
                    else if (sclFall && cnt_reg == asc_pkg::BYTE_BITS)
                    begin
                        if (state_reg == asc_pkg::I2C_ADDR)
                        begin
                            if (shift_reg[7:1] == addr_reg)
                            begin
                                rw_next    = shift_reg[0];
                                drive_next = 1'b1;
                                state_next = asc_pkg::I2C_ADDR_ACK;
                            end
                            else
                            begin
                                state_next = asc_pkg::I2C_IDLE;
                            end
                        end
                        else
                        begin
                            // whole-byte writes: host must read-modify-write
                            if (first_reg)
                            begin
                                ptr_next = shift_reg;
                            end
                            else
                            begin
                                if (ptr_reg == asc_pkg::ORIENT_CTRL_OFS)
                                begin
                                    orient_next = shift_reg;
                                end
                                else if (ptr_reg == asc_pkg::SHARE_CTRL_OFS)
                                begin
                                    share_next = shift_reg;
                                end
                                ptr_next = ptr_reg + 8'h01;
                            end
                            first_next = 1'b0;
                            drive_next = 1'b1;
                            state_next = asc_pkg::I2C_WBYTE_ACK;
                        end
                    end
                end
                asc_pkg::I2C_ADDR_ACK:
                begin
                    if (sclFall)
                    begin
                        cnt_next = 4'h0;
                        if (rw_reg)
                        begin
                            tx_next    = readReg(ptr_reg, orient_reg, share_reg);
                            drive_next = !tx_next[7];
                            state_next = asc_pkg::I2C_RBYTE;
                        end
                        else
                        begin
                            first_next = 1'b1;
                            drive_next = 1'b0;
                            state_next = asc_pkg::I2C_WBYTE;
                        end
                    end
                end
                asc_pkg::I2C_WBYTE_ACK:
                begin
                    if (sclFall)
                    begin
                        cnt_next   = 4'h0;
                        drive_next = 1'b0;
                        state_next = asc_pkg::I2C_WBYTE;
                    end
                end
                asc_pkg::I2C_RBYTE:
                begin
                    if (sclFall)
                    begin
                        if (cnt_reg == asc_pkg::BYTE_LAST_BIT)
                        begin
                            drive_next = 1'b0;
                            ptr_next   = ptr_reg + 8'h01;
                            state_next = asc_pkg::I2C_RBYTE_ACK;
                        end
                        else
                        begin
                            cnt_next   = cnt_reg + 4'h1;
                            tx_next    = {tx_reg[6:0], 1'b0};
                            drive_next = !tx_reg[6];
                        end
                    end
                end
                asc_pkg::I2C_RBYTE_ACK:
                begin
                    if (sclRise)
                    begin
                        nack_next = pinsSync_reg.sda;
                    end
                    else if (sclFall)
                    begin
                        if (nack_reg)
                        begin
                            state_next = asc_pkg::I2C_IDLE;
                        end
                        else
                        begin
                            cnt_next   = 4'h0;
                            tx_next    = readReg(ptr_reg, orient_reg, share_reg);
                            drive_next = !tx_next[7];
                            state_next = asc_pkg::I2C_RBYTE;
                        end
                    end
                end
                default:
                begin
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg  <= asc_pkg::I2C_IDLE;
            shift_reg  <= 8'h00;
            tx_reg     <= 8'h00;
            cnt_reg    <= 4'h0;
            ptr_reg    <= 8'h00;
            rw_reg     <= 1'b0;
            first_reg  <= 1'b0;
            nack_reg   <= 1'b0;
            drive_reg  <= 1'b0;
            orient_reg <= asc_pkg::ORIENT_CTRL_RST;
            share_reg  <= asc_pkg::SHARE_CTRL_RST;
        end
        else if (ce)
        begin
            state_reg  <= state_next;
            shift_reg  <= shift_next;
            tx_reg     <= tx_next;
            cnt_reg    <= cnt_next;
            ptr_reg    <= ptr_next;
            rw_reg     <= rw_next;
            first_reg  <= first_next;
            nack_reg   <= nack_next;
            drive_reg  <= drive_next;
            orient_reg <= orient_next;
            share_reg  <= share_next;
        end
    end

    // ---------------------------------------------------------------
    // snoop monitor and lane power
    // ---------------------------------------------------------------
    asc_pkg::asc_snoop_s              snoop_reg;
    asc_pkg::asc_snoop_s              snoop_next;
    logic [asc_pkg::LANES-1:0]        lanePd_reg;
    logic [asc_pkg::LANES-1:0]        lanePd_next;
    logic                             sideband_pos_pin;
    logic                             sideband_neg_pin;
    logic                             auxLevel;
    logic                             lsLevel;

    // monitor only listens; it never drives the sideband pair
    function automatic logic laneUnused(input int idx, input logic [2:0] active, input logic d3);
        return d3 || (idx >= int'(active));
    endfunction

    always_comb
    begin
        // swap which pin is treated as positive
        sideband_pos_pin     = orient_reg[asc_pkg::AUX_POL_BIT] ? pinsSync_reg.sidebandNeg
                                                    : pinsSync_reg.sidebandPos;
        sideband_neg_pin     = orient_reg[asc_pkg::AUX_POL_BIT] ? pinsSync_reg.sidebandPos
                                                    : pinsSync_reg.sidebandNeg;
        auxLevel = sideband_pos_pin && !sideband_neg_pin;
        // shared mode takes low-speed from the aux pair too
        if (share_reg[asc_pkg::PIN_SHARE_BIT])
        begin
            lsLevel = auxLevel;
        end
        else
        begin
            lsLevel = pinsSync_reg.lowspeedIn ^ pinsSync_reg.lowspeedOut;
        end
        snoop_next.auxData = auxLevel;
        snoop_next.auxEdge = auxLevel != snoop_reg.auxData;
        snoop_next.lsData  = lsLevel;
        snoop_next.lsEdge  = lsLevel != snoop_reg.lsData;
        for (int i = 0; i < asc_pkg::LANES; i++)
        begin
            // lane order 0 maps lane i to pin i unchanged
            if (share_reg[asc_pkg::LANE_ORDER_BIT])
            begin
                lanePd_next[asc_pkg::LANES-1-i] = laneUnused(i, pinsSync_reg.activeLanes,
                                                             pinsSync_reg.linkD3);
            end
            else
            begin
                lanePd_next[i] = laneUnused(i, pinsSync_reg.activeLanes,
                                            pinsSync_reg.linkD3);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            snoop_reg  <= '0;
            lanePd_reg <= '1;
        end
        else if (ce)
        begin
            snoop_reg  <= snoop_next;
            lanePd_reg <= lanePd_next;
        end
    end

    assign sdaOut        = 1'b0;
    assign sdaOeN        = !drive_reg;
    assign snoop         = snoop_reg;
    assign lanePowerDown = lanePd_reg;
    assign slaveAddr     = addr_reg;
    assign orientCtrl    = orient_reg;
    assign shareCtrl     = share_reg;

endmodule
`default_nettype wire

// [core/asc_pkg.sv]
// package: register map, field positions, reset values and shared types for the snoop block
package asc_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ORIENT_CTRL_OFS  = 8'h04;
    localparam logic [7:0] SHARE_CTRL_OFS   = 8'h05;
    localparam logic [7:0] ORIENT_CTRL_RST  = 8'h00;
    localparam logic [7:0] SHARE_CTRL_RST   = 8'h00;
    localparam int         AUX_POL_BIT      = 3;
    localparam int         ORIENT_BIT       = 4;
    localparam int         PIN_SHARE_BIT    = 1;
    localparam int         LANE_ORDER_BIT   = 2;

    // ---------------------------------------------------------------
    // i2c slave addressing, byte framing and states; lane count
    // ---------------------------------------------------------------
    localparam logic [6:0] I2C_ADDR_BASE    = 7'h30;
    localparam logic [3:0] BYTE_LAST_BIT    = 4'h7;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam int         LANES            = 4;

    typedef enum {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ADDR_ACK,
        I2C_WBYTE,
        I2C_WBYTE_ACK,
        I2C_RBYTE,
        I2C_RBYTE_ACK
    } asc_i2c_state_e;

    // pins that arrive from outside and pass the two-stage synchroniser
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       sidebandPos;
        logic       sidebandNeg;
        logic       lowspeedIn;
        logic       lowspeedOut;
        logic       linkD3;
        logic [2:0] activeLanes;
        logic [1:0] addrStrap;
    } asc_pins_s;

    typedef struct packed {
        logic auxData;
        logic auxEdge;
        logic lsData;
        logic lsEdge;
    } asc_snoop_s;

endpackage

// [tb/asc_i2c_host.sv]
// partner: i2c host model that configures the block over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module asc_i2c_host
(
    // clock and device pull
    input  wire logic clk_sys,
    input  wire logic sdaOeN,
    // bus levels seen by all parties
    output logic      scl,
    output logic      sda
);
    localparam int HALF = 6;
    logic sdaDrv = 1'b1;
    // wired-and with the pull-up: a released line floats high
    assign sda = sdaDrv & sdaOeN;
    initial scl = 1'b1;

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // data settles a full half period before scl rises, sampled mid-high
    task automatic clkPulse(output logic s);
        tick(HALF);
        scl = 1'b1;
        tick(HALF / 2);
        s = sda;
        tick(HALF / 2);
        scl = 1'b0;
    endtask

    task automatic startCond();
        sdaDrv = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaDrv = 1'b0;
        tick(HALF);
        scl = 1'b0;
    endtask

    task automatic stopCond();
        sdaDrv = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaDrv = 1'b1;
        tick(HALF);
    endtask

    task automatic putByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            sdaDrv = b[i];
            clkPulse(s);
        end
        sdaDrv = 1'b1;
        clkPulse(s);
        ack = !s;
    endtask

    // last set releases the ninth bit, a nack that ends the read
    task automatic getByte(input logic last, output logic [7:0] b);
        logic s;
        sdaDrv = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            clkPulse(s);
            b = {b[6:0], s};
        end
        sdaDrv = last;
        clkPulse(s);
    endtask

    task automatic writeReg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] val,
                            output logic ok);
        logic a0, a1, a2;
        startCond();
        putByte({a, 1'b0}, a0);
        putByte(ofs, a1);
        putByte(val, a2);
        stopCond();
        ok = a0 & a1 & a2;
    endtask

    task automatic readReg(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] val,
                           output logic ok);
        logic a0, a1, a2;
        startCond();
        putByte({a, 1'b0}, a0);
        putByte(ofs, a1);
        startCond();
        putByte({a, 1'b1}, a2);
        getByte(1'b1, val);
        stopCond();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// [tb/asc_snoop_config_assertions.sv]
// checker: port-level assertions for the snoop and configuration block
`timescale 1ns/1ps
`default_nettype none
module asc_snoop_config_assertions
(
    // clock, reset, enable
    input wire logic                      clk_sys,
    input wire logic                      rst,
    input wire logic                      ce,
    // pins and outputs
    input wire asc_pkg::asc_pins_s        pins,
    input wire logic                      sdaOut,
    input wire logic                      sdaOeN,
    input wire asc_pkg::asc_snoop_s       snoop,
    input wire logic [asc_pkg::LANES-1:0] lanePowerDown,
    input wire logic [6:0]                slaveAddr,
    input wire logic [7:0]                orientCtrl,
    input wire logic [7:0]                shareCtrl
);
    // ---------------------------------------------------------------
    // helper logic
    // ---------------------------------------------------------------
    // age gate keeps $stable away from values held during reset
    logic [2:0] ageReg;
    logic [2:0] ageNext;
    logic       ready;
    logic       auxExp;
    logic [3:0] laneExp;
    always_comb
    begin
        ageNext = (ageReg == 3'h7) ? ageReg : ageReg + 3'h1;
        ready = (ageReg == 3'h7);
        auxExp = orientCtrl[asc_pkg::AUX_POL_BIT] ? (pins.sidebandNeg & !pins.sidebandPos)
                                                  : (pins.sidebandPos & !pins.sidebandNeg);
        for (int i = 0; i < 4; i++)
            laneExp[i] = pins.linkD3 | (i >= int'(pins.activeLanes));
    end
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            ageReg <= 3'h0;
        else if (ce)
            ageReg <= ageNext;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    reset_vals_a: assert property ($fell(rst) |-> !(orientCtrl | shareCtrl))
        else $error("control registers not clear after reset");
    sda_drive_a: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    addr_strap_a: assert property (ready |-> slaveAddr == 7'h30 + pins.addrStrap)
        else $error("slave address does not follow strap");
    ack_timing_a: assert property ($changed(sdaOeN) |-> !pins.scl)
        else $error("data drive changed while clock high");
    lane_power_a: assert property ((ready && !shareCtrl[asc_pkg::LANE_ORDER_BIT]
        && $stable({pins.linkD3, pins.activeLanes}))[*4] |-> lanePowerDown == laneExp)
        else $error("lane power does not match lane count");
    aux_polarity_a: assert property ((ready && $stable({pins.sidebandPos,
        pins.sidebandNeg, orientCtrl, shareCtrl}))[*4] |-> snoop.auxData == auxExp)
        else $error("aux snoop level wrong for polarity");
    ls_separate_a: assert property ((ready && !shareCtrl[asc_pkg::PIN_SHARE_BIT]
        && $stable({pins.lowspeedIn, pins.lowspeedOut, shareCtrl}))[*4]
        |-> snoop.lsData == (pins.lowspeedIn ^ pins.lowspeedOut))
        else $error("low-speed snoop not from own pins");
    ls_shared_a: assert property ((ready && shareCtrl[asc_pkg::PIN_SHARE_BIT]
        && $stable({pins.sidebandPos, pins.sidebandNeg, orientCtrl, shareCtrl}))[*4]
        |=> $stable(snoop.lsData))
        else $error("shared mode low-speed snoop moved by own pins");
    aux_pulse_a: assert property (snoop.auxEdge |=> !snoop.auxEdge)
        else $error("aux edge pulse too long");
    ls_pulse_a: assert property (snoop.lsEdge |=> !snoop.lsEdge)
        else $error("low-speed edge pulse too long");
endmodule

bind asc_snoop_config asc_snoop_config_assertions chk (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .pins(pins), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .snoop(snoop),
    .lanePowerDown(lanePowerDown), .slaveAddr(slaveAddr), .orientCtrl(orientCtrl),
    .shareCtrl(shareCtrl));
`default_nettype wire

// [tb/testbench.sv]
// testbench: register, snoop, lane power and address strap scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                 clk_sys = 1'b0;
    logic                 rst = 1'b1;
    logic                 pos = 1'b0, neg = 1'b0, lsIn = 1'b0, lsOut = 1'b0, d3 = 1'b0;
    logic [2:0]           lanes = 3'h4;
    logic [1:0]           strap = 2'h0;
    logic [6:0]           addrNow = 7'h30;
    logic                 scl, sda, sdaOut, sdaOeN;
    asc_pkg::asc_pins_s   pinsBus;
    asc_pkg::asc_snoop_s  snoop;
    logic [3:0]           lpd;
    logic [6:0]           addr;
    logic [7:0]           orient, share;
    int                   n_mismatch = 0;
    int                   tests_run = 0;

    always #5 clk_sys = ~clk_sys;
    assign pinsBus = {scl, sda, pos, neg, lsIn, lsOut, d3, lanes, strap};

    asc_i2c_host host (.clk_sys(clk_sys), .sdaOeN(sdaOeN), .scl(scl), .sda(sda));
    asc_snoop_config uut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .pins(pinsBus),
        .sdaOut(sdaOut), .sdaOeN(sdaOeN), .snoop(snoop), .lanePowerDown(lpd),
        .slaveAddr(addr), .orientCtrl(orient), .shareCtrl(share));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic pause(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
        logic ok;
        host.writeReg(addrNow, ofs, val, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
        logic ok;
        host.readReg(addrNow, ofs, v, ok);
        check({7'h00, ok}, 8'h01);
    endtask

    task automatic doReset(input logic [1:0] s);
        rst = 1'b1;
        strap = s;
        addrNow = 7'h30 | {5'h00, s};
        pause(2);
        rst = 1'b0;
        pause(4);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_defaults();
        logic [7:0] v;
        rd(asc_pkg::ORIENT_CTRL_OFS, v);
        check(v, 8'h00);
        rd(asc_pkg::SHARE_CTRL_OFS, v);
        check(v, 8'h00);
        wr(8'h07, 8'h5a);
        rd(8'h07, v);
        check(v, 8'h00);
        $display("test defaults done");
    endtask

    task automatic test_polarity();
        logic [7:0] v;
        for (int k = 0; k < 2; k++)
        begin
            rd(asc_pkg::ORIENT_CTRL_OFS, v);
            wr(asc_pkg::ORIENT_CTRL_OFS, v ^ 8'h18);
            check(orient, k == 0 ? 8'h18 : 8'h00);
            for (int p = 1; p < 3; p++)
            begin
                {pos, neg} = 2'(p);
                pause(6);
                check({7'h00, snoop.auxData}, 8'(p == k + 1));
            end
        end
        $display("test polarity done");
    endtask

    task automatic test_share();
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            {lsIn, lsOut} = 2'(i);
            pause(6);
            check({7'h00, snoop.lsData}, {7'h00, lsIn ^ lsOut});
        end
        rd(asc_pkg::SHARE_CTRL_OFS, v);
        wr(asc_pkg::SHARE_CTRL_OFS, v | 8'h02);
        check(share, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            {pos, neg} = 2'(i);
            {lsIn, lsOut} = 2'(i + 1);
            pause(6);
            check({7'h00, snoop.lsData}, {7'h00, pos & !neg});
        end
        wr(asc_pkg::SHARE_CTRL_OFS, v);
        $display("test share done");
    endtask

    task automatic test_lanes();
        logic [3:0] exp;
        for (int d = 0; d < 2; d++)
            for (int n = 0; n < 5; n++)
            begin
                d3 = d[0];
                lanes = 3'(n);
                pause(6);
                for (int i = 0; i < 4; i++)
                    exp[i] = (d == 1) || (i >= n);
                check({4'h0, lpd}, {4'h0, exp});
            end
        d3 = 1'b0;
        lanes = 3'h1;
        wr(asc_pkg::SHARE_CTRL_OFS, 8'h04);
        pause(6);
        check({4'h0, lpd}, 8'h07);
        $display("test lanes done");
    endtask

    task automatic test_addr();
        logic ok;
        for (int s = 0; s < 4; s++)
        begin
            doReset(2'(s));
            check({1'b0, addr}, {1'b0, 7'h30 | 7'(s)});
            host.writeReg(addrNow ^ 7'h01, asc_pkg::SHARE_CTRL_OFS, 8'h02, ok);
            check({7'h00, ok}, 8'h00);
            check(share, 8'h00);
            wr(asc_pkg::ORIENT_CTRL_OFS, 8'h18);
        end
        $display("test addr done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // a full run needs about 80 us; a hang is cut off well after that
    initial
    begin
        #600us;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        doReset(2'h0);
        test_defaults();
        test_polarity();
        test_share();
        test_lanes();
        test_addr();
        summarize();
    end
endmodule
`default_nettype wire
